/* File: adc_ctrl_pkg.sv */
package adc_ctrl_pkg;
  localparam logic [15:0] MODE_ADDR = 16'hFF28;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int RUN_BIT = 7;
  localparam int ZERO_BIT = 6;
  localparam int DIV_LSB = 3;
  localparam int DIV_W = 3;
  localparam int RANGE_LSB = 1;
  localparam int RANGE_W = 2;
  localparam int CMP_BIT = 0;
  localparam logic [1:0] RANGE_LOW = 2'h1;
  localparam logic [2:0] DIV_MAX_CODE = 3'h5;
  // divide ratio per divider code, index 5 first
  localparam logic [5:0][3:0] DIV_RATIO = {4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hC};
  localparam logic [4:0] CLEAR_TICKS = 5'h02;
  localparam logic [4:0] SAMPLE_TICKS_STD = 5'h06;
  localparam logic [4:0] SAMPLE_TICKS_LOW = 5'h18;
  localparam logic [4:0] APPROX_TICKS = 5'h0C;
  localparam logic [4:0] XFER_TICKS = 5'h02;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1)
                              / CLK_PERIOD_PS;
  typedef enum logic [5:0] {
    ST_STOP   = 6'h01,
    ST_WAIT   = 6'h02,
    ST_CLEAR  = 6'h04,
    ST_SAMPLE = 6'h08,
    ST_APPROX = 6'h10,
    ST_XFER   = 6'h20
  } conv_state_t;
endpackage

/* File: conv_clock_div.sv */
`timescale 1ns/10ps
module conv_clock_div (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [2:0] div_code,
  output logic tick
);
  typedef struct packed {
    logic [3:0] cnt;
    logic tick;
  } div_st_t;
  div_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    // prohibited codes give no conversion clock at all
    if (!run || div_code > adc_ctrl_pkg::DIV_MAX_CODE) begin
      st_d.cnt = 4'h0;
    end else if (st_q.cnt == adc_ctrl_pkg::DIV_RATIO[div_code] - 4'h1) begin
      st_d.cnt = 4'h0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;
endmodule

/* File: adc_mode_timing_control.sv */
`timescale 1ns/10ps
module adc_mode_timing_control #(
  parameter int RES_BITS = 10
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_bit_wr,
  input wire logic [2:0] bus_bit_sel,
  input wire logic bus_bit_val,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  output logic bus_wait,
  input wire logic comparator_in,
  output logic comparator_power,
  output logic sample_hold,
  output logic [RES_BITS-1:0] dac_code,
  output logic [RES_BITS-1:0] conv_result,
  output logic result_suspect,
  output logic conv_done_irq,
  output logic conv_active
);
  initial begin
    if (RES_BITS < 2 || RES_BITS > int'(adc_ctrl_pkg::APPROX_TICKS)) begin
      $error("RES_BITS out of range");
    end
  end

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] rdata;
    logic wait_st;
    adc_ctrl_pkg::conv_state_t state;
    logic [4:0] phase;
    logic [RES_BITS-1:0] sar;
    logic [RES_BITS-1:0] result;
    logic done;
    logic suspect;
    logic first;
    logic sh;
    logic active;
    logic [8:0] settle_cnt;
    logic settled;
    logic [11:0] chk_cnt;
    logic chk_seen;
  } ctl_st_t;
  ctl_st_t st_q, st_d;

  logic tick;
  logic hit;
  logic run;
  logic low_range;
  logic [4:0] lim;
  int bit_idx;

  assign hit = bus_addr == adc_ctrl_pkg::MODE_ADDR;
  assign run = st_q.mode[adc_ctrl_pkg::RUN_BIT];
  assign low_range = st_q.mode[adc_ctrl_pkg::RANGE_LSB +: adc_ctrl_pkg::RANGE_W]
                     == adc_ctrl_pkg::RANGE_LOW;

  conv_clock_div u_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .run(run),
    .div_code(st_q.mode[adc_ctrl_pkg::DIV_LSB +: adc_ctrl_pkg::DIV_W]),
    .tick(tick)
  );

  always_comb begin
    st_d = st_q;
    bit_idx = RES_BITS - 1 - int'(st_q.phase);
    lim = adc_ctrl_pkg::CLEAR_TICKS;
    unique case (st_q.state)
      adc_ctrl_pkg::ST_SAMPLE: lim = low_range ?
        adc_ctrl_pkg::SAMPLE_TICKS_LOW : adc_ctrl_pkg::SAMPLE_TICKS_STD;
      adc_ctrl_pkg::ST_APPROX: lim = adc_ctrl_pkg::APPROX_TICKS;
      adc_ctrl_pkg::ST_XFER: lim = adc_ctrl_pkg::XFER_TICKS;
      adc_ctrl_pkg::ST_STOP, adc_ctrl_pkg::ST_WAIT,
      adc_ctrl_pkg::ST_CLEAR: lim = adc_ctrl_pkg::CLEAR_TICKS;
    endcase
    // register access
    st_d.wait_st = (bus_wr || bus_bit_wr) && hit;
    if (bus_wr && hit) begin
      st_d.mode = bus_wdata;
    end else if (bus_bit_wr && hit) begin
      st_d.mode[bus_bit_sel] = bus_bit_val;
    end
    st_d.mode[adc_ctrl_pkg::ZERO_BIT] = 1'b0;
    st_d.rdata = (bus_rd && hit) ? st_q.mode : 8'h00;
    // comparator settling, seen only to flag an unsure first result
    if (!st_q.mode[adc_ctrl_pkg::CMP_BIT]) begin
      st_d.settle_cnt = 9'h000;
      st_d.settled = 1'b0;
    end else if (st_q.settle_cnt == 9'(adc_ctrl_pkg::SETTLE_CYC - 1)) begin
      st_d.settled = 1'b1;
    end else begin
      st_d.settle_cnt = st_q.settle_cnt + 9'h001;
    end
    st_d.done = 1'b0;
    if (!run) begin
      // abort drops the partial result on the floor
      st_d.state = st_q.mode[adc_ctrl_pkg::CMP_BIT] ?
        adc_ctrl_pkg::ST_WAIT : adc_ctrl_pkg::ST_STOP;
      st_d.phase = 5'h00;
      st_d.sh = 1'b0;
    end else if (st_q.state == adc_ctrl_pkg::ST_STOP ||
                 st_q.state == adc_ctrl_pkg::ST_WAIT) begin
      st_d.state = adc_ctrl_pkg::ST_CLEAR;
      st_d.phase = 5'h00;
      st_d.first = !st_q.settled;
    end else if (tick) begin
      st_d.phase = st_q.phase + 5'h01;
      if (st_q.state == adc_ctrl_pkg::ST_APPROX &&
          st_q.phase < 5'(RES_BITS)) begin
        // latched comparator runs on this clock; a two-stage sync would
        // need three cycles a bit and break the divide-by-two setting
        st_d.sar[bit_idx] = comparator_in;
        if (bit_idx > 0) begin
          st_d.sar[bit_idx - 1] = 1'b1;
        end
      end
      if (st_q.phase == lim - 5'h01) begin
        st_d.phase = 5'h00;
        unique case (st_q.state)
          adc_ctrl_pkg::ST_CLEAR: begin
            st_d.state = adc_ctrl_pkg::ST_SAMPLE;
            st_d.sar = '0;
            st_d.sh = 1'b1;
          end
          adc_ctrl_pkg::ST_SAMPLE: begin
            st_d.state = adc_ctrl_pkg::ST_APPROX;
            st_d.sh = 1'b0;
            st_d.sar = '0;
            st_d.sar[RES_BITS-1] = 1'b1;
          end
          adc_ctrl_pkg::ST_APPROX: st_d.state = adc_ctrl_pkg::ST_XFER;
          adc_ctrl_pkg::ST_XFER: begin
            st_d.state = adc_ctrl_pkg::ST_CLEAR;
            st_d.result = st_q.sar;
            st_d.done = 1'b1;
            st_d.suspect = st_q.first;
            st_d.first = 1'b0;
          end
          adc_ctrl_pkg::ST_STOP, adc_ctrl_pkg::ST_WAIT: begin
            st_d.state = st_q.state;
          end
        endcase
      end
    end
    st_d.active = !(st_d.state == adc_ctrl_pkg::ST_STOP ||
                    st_d.state == adc_ctrl_pkg::ST_WAIT);
    // helper for the period check: cycles between done pulses
    st_d.chk_cnt = st_d.done ? 12'h000 : st_q.chk_cnt + 12'h001;
    if (!run || st_d.wait_st) begin
      st_d.chk_seen = 1'b0;
    end else if (st_d.done) begin
      st_d.chk_seen = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= '0;
      st_q.mode <= adc_ctrl_pkg::MODE_RESET;
      st_q.state <= adc_ctrl_pkg::ST_STOP;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus_rdata = st_q.rdata;
  assign bus_wait = st_q.wait_st;
  assign comparator_power = st_q.mode[adc_ctrl_pkg::CMP_BIT];
  assign sample_hold = st_q.sh;
  assign dac_code = st_q.sar;
  assign conv_result = st_q.result;
  assign result_suspect = st_q.suspect;
  assign conv_done_irq = st_q.done;
  assign conv_active = st_q.active;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic [11:0] period_exp;
  assign period_exp = 12'(int'(adc_ctrl_pkg::DIV_RATIO[
    st_q.mode[adc_ctrl_pkg::DIV_LSB +: adc_ctrl_pkg::DIV_W]]) *
    int'(adc_ctrl_pkg::CLEAR_TICKS + lim_sample() +
    adc_ctrl_pkg::APPROX_TICKS + adc_ctrl_pkg::XFER_TICKS));

  function automatic logic [4:0] lim_sample();
    return low_range ? adc_ctrl_pkg::SAMPLE_TICKS_LOW :
      adc_ctrl_pkg::SAMPLE_TICKS_STD;
  endfunction

  sequence write_hit_s;
    (bus_wr || bus_bit_wr) && hit;
  endsequence
  sequence wait_pulse_s;
    bus_wait ##1 !bus_wait;
  endsequence

  reset_clear_a: assert property ($fell(reset) |-> st_q.mode == 8'h00)
    else $error("mode register not zero after reset");
  bit6_zero_a: assert property (!st_q.mode[adc_ctrl_pkg::ZERO_BIT])
    else $error("mode bit 6 not zero");
  stop_idle_a: assert property (!run |=> !conv_active && !sample_hold)
    else $error("converter active with run clear");
  wait_mode_a: assert property (!run && comparator_power |=>
    st_q.state == adc_ctrl_pkg::ST_WAIT) else $error("not in waiting mode");
  write_wait_a: assert property (write_hit_s |=> wait_pulse_s)
    else $error("write wait cycle missing");
  abort_done_a: assert property (!run |=> !conv_done_irq)
    else $error("done pulse after abort");
  sar_msb_a: assert property (
    $rose(st_q.state == adc_ctrl_pkg::ST_APPROX)
    |-> dac_code == {1'b1, {(RES_BITS-1){1'b0}}})
    else $error("approximation does not start at msb");
  xfer_a: assert property (
    conv_done_irq |-> conv_result == $past(dac_code))
    else $error("result differs from approximation register");
  repeat_a: assert property (
    conv_done_irq && run |=> st_q.state == adc_ctrl_pkg::ST_CLEAR)
    else $error("conversion does not repeat");
  period_a: assert property (
    conv_done_irq && $past(st_q.chk_seen) && run
    |-> $past(st_q.chk_cnt) + 12'h001 == period_exp)
    else $error("conversion period wrong");
endmodule

/* File: analog_input_model.sv */
`timescale 1ns/10ps
module analog_input_model #(
  parameter int RES_BITS = 10
) (
  input wire logic sys_clk,
  input wire logic [RES_BITS-1:0] level,
  input wire logic comparator_power,
  input wire logic sample_hold,
  input wire logic [RES_BITS-1:0] dac_code,
  output logic comparator_in
);
  logic [RES_BITS-1:0] held_q = '0;
  logic noise_q = 1'b0;
  // track the input while sampling, hold it for the approximation
  always_ff @(posedge sys_clk) begin
    noise_q <= ~noise_q;
    if (sample_hold) begin
      held_q <= level;
    end
  end
  // an unpowered comparator gives junk, so no result passes by luck
  assign comparator_in = comparator_power ? (held_q >= dac_code) : noise_q;
endmodule

/* File: adc_mode_timing_control_tb.sv */
`timescale 1ns/10ps
module adc_mode_timing_control_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] bus_addr = 16'hFF28;
  logic bus_wr = 1'b0, bus_bit_wr = 1'b0, bus_bit_val = 1'b0, bus_rd = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic [2:0] bus_bit_sel = 3'h0;
  logic [9:0] level = 10'h000;
  logic [7:0] bus_rdata;
  logic bus_wait, comparator_in, comparator_power, sample_hold;
  logic result_suspect, conv_done_irq, conv_active;
  logic [9:0] dac_code, conv_result;
  logic [31:0] rng = 32'h51;
  int num_errors = 0;
  int compares = 0;

  adc_mode_timing_control #(.RES_BITS(10)) adc_mode_timing_control_inst (
    .sys_clk, .reset, .bus_addr, .bus_wr, .bus_wdata, .bus_bit_wr,
    .bus_bit_sel, .bus_bit_val, .bus_rd, .bus_rdata, .bus_wait,
    .comparator_in, .comparator_power, .sample_hold, .dac_code,
    .conv_result, .result_suspect, .conv_done_irq, .conv_active);
  analog_input_model #(.RES_BITS(10)) analog_input_model_inst (
    .sys_clk, .level, .comparator_power, .sample_hold, .dac_code,
    .comparator_in);

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // inputs move 1 ns after the edge, never on it
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] d);
    bus_wdata = d;
    bus_wr = 1'b1;
    cyc(1);
    bus_wr = 1'b0;
    check(bus_wait, 1'b1);
    cyc(1);
    check(bus_wait, 1'b0);
  endtask
  task automatic bwr(input logic [2:0] s, input logic v);
    bus_bit_sel = s;
    bus_bit_val = v;
    bus_bit_wr = 1'b1;
    cyc(1);
    bus_bit_wr = 1'b0;
    check(bus_wait, 1'b1);
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] exp);
    bus_rd = 1'b1;
    cyc(1);
    bus_rd = 1'b0;
    check(bus_rdata, exp);
    cyc(1);
  endtask
  // first check is skipped so a pulse already seen is not counted twice
  task automatic wait_done(output int n);
    cyc(1);
    n = 1;
    while (conv_done_irq !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 3000) begin
        num_errors++;
        end_sim();
      end
    end
  endtask

  initial begin
    int n;
    int ratio[6] = '{12, 8, 6, 4, 3, 2};
    logic [9:0] prev;
    cyc(16);
    reset = 1'b0;
    rd(8'h00);
    bus_addr = 16'hFF29;
    rd(8'h00);
    bus_addr = 16'hFF28;
    wr(8'h7E);
    rd(8'h3E);
    check(conv_active, 1'b0);
    wr(8'h00);
    bwr(3'h0, 1'b1);
    check(comparator_power, 1'b1);
    bwr(3'h6, 1'b1);
    rd(8'h01);
    cyc(250);
    for (int r = 0; r < 2; r++) begin
      for (int d = 0; d < 6; d++) begin
        rng = xorshift(rng);
        level = rng[9:0];
        // fields change only while stopped; clock is fast limits
        wr({2'b10, 3'(d), 2'(r), 1'b1});
        check(conv_active, 1'b1);
        wait_done(n);
        check(conv_result, level);
        check(result_suspect, 1'b0);
        wait_done(n);
        check(16'(n), 16'(ratio[d] * (r ? 40 : 22)));
        check(conv_result, level);
        wr({2'b00, 3'(d), 2'(r), 1'b1});
        check(conv_active, 1'b0);
      end
    end
    prev = conv_result;
    level = ~level;
    wr(8'h81);
    cyc(100);
    wr(8'h01);
    check(conv_active, 1'b0);
    repeat (600) begin
      cyc(1);
      check(conv_done_irq, 1'b0);
    end
    check(conv_result, prev);
    bwr(3'h0, 1'b0);
    check(comparator_power, 1'b0);
    wr(8'hA8);
    wait_done(n);
    check(result_suspect, 1'b1);
    wait_done(n);
    check(16'(n), 16'd44);
    wr(8'h00);
    check(conv_active, 1'b0);
    end_sim();
  end
endmodule
